// *** core/dou_conv1_ctrl.sv ***
// Purpose: Register, update scheduling and word alignment for converter one
// Assumes: Bus and timer overflow inputs synchronous to i_sys_clk, pulses one cycle
// Notes:   Read data appears one cycle after the read strobe
//
// What this block does
// - Enable clear disables pin, shuts converter down
// - Enable set drives pin, converter operational
// - Control bits 6:5 read zero, ignore writes
// - Update mode field sits in control bits 4:3
// - Mode 00 loads latch on high write
// - Mode 01 loads latch on timer 3
// - Mode 10 loads latch on timer 4
// - Mode 11 loads latch on timer 2
// - Data format field sits in control bits 2:0
// - Format 000: high[3:0] over whole low
// - Format 001: high[4:0] over low[7:1]
// - Format 010: high[5:0] over low[7:2]
// - Format 011: high[6:0] over low[7:3]
// - Format 1xx: whole high over low[7:4]
// - Mode 00 holds low write until high write
// - Timer modes hold both bytes until overflow
// - Low reads written value, high reads latched
// - Same behaviour as converter zero, own addresses
`timescale 1ns/1ps
`default_nettype none

module dou_conv1_ctrl (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_reset_n,
    input  wire dou_pkg::dou_sfr_req_type i_sfr,
    input  wire dou_pkg::dou_ovf_type     i_ovf,
    output logic [7:0]                    o_sfr_rdata,
    output logic [11:0]                   o_conv_code,
    output logic                          o_conv_enable,
    output logic                          o_conv_shutdown
);

    // ----------------------------------------------------------------
    // Alignment of the two bytes into the 12-bit word
    // ----------------------------------------------------------------
    function automatic logic [11:0] fmt_word(input logic [2:0] fmt,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [11:0] w;
        w = 12'h000;
        if (fmt[2]) begin
            w = {hi[7:0], lo[7:4]};
        end else begin
            unique case (dou_pkg::dou_fmt_type'(fmt))
                dou_pkg::DOU_FMT_NIBBLE: w = {hi[3:0], lo[7:0]};
                dou_pkg::DOU_FMT_FIVE:   w = {hi[4:0], lo[7:1]};
                dou_pkg::DOU_FMT_SIX:    w = {hi[5:0], lo[7:2]};
                dou_pkg::DOU_FMT_SEVEN:  w = {hi[6:0], lo[7:3]};
            endcase
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]  low_r;
    logic [7:0]  high_r;
    logic [7:0]  high_lat_r;
    logic [7:0]  ctl_r;
    logic [11:0] code_r;
    logic [7:0]  rdata_r;
    logic        enable_r;
    logic        shutdown_r;

    logic [7:0]  low_nxt;
    logic [7:0]  high_nxt;
    logic [7:0]  high_lat_nxt;
    logic [7:0]  ctl_nxt;
    logic [11:0] code_nxt;
    logic [7:0]  rdata_nxt;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire                       wr_low  = i_sfr.wr && (i_sfr.addr == dou_pkg::ADDR_DATA_LOW);
    wire                       wr_high = i_sfr.wr && (i_sfr.addr == dou_pkg::ADDR_DATA_HIGH);
    wire                       wr_ctl  = i_sfr.wr && (i_sfr.addr == dou_pkg::ADDR_CONTROL);
    wire dou_pkg::dou_mode_type mode   =
        dou_pkg::dou_mode_type'(ctl_r[dou_pkg::CTL_MODE_HI:dou_pkg::CTL_MODE_LO]);
    wire [2:0]                 fmt     = ctl_r[dou_pkg::CTL_FMT_HI:dou_pkg::CTL_FMT_LO];
    wire                       en_nxt  = ctl_nxt[dou_pkg::CTL_ENABLE_BIT];

    // Selected overflow; one pulse gives one load
    wire tmr_hit = (mode == dou_pkg::DOU_MODE_TIMER3 && i_ovf.tmr3)
                || (mode == dou_pkg::DOU_MODE_TIMER4 && i_ovf.tmr4)
                || (mode == dou_pkg::DOU_MODE_TIMER2 && i_ovf.tmr2);
    wire wr_load = (mode == dou_pkg::DOU_MODE_ON_WRITE) && wr_high;

    // Write-triggered load sees the new high byte with the held low byte
    wire [11:0] wr_word  = fmt_word(fmt, i_sfr.wdata, low_r);
    // Timer load copies held contents; a same-cycle write lands afterwards
    wire [11:0] tmr_word = fmt_word(fmt, high_r, low_r);

    assign low_nxt      = wr_low ? i_sfr.wdata : low_r;
    assign high_nxt     = wr_high ? i_sfr.wdata : high_r;
    assign ctl_nxt      = wr_ctl ? (i_sfr.wdata & dou_pkg::CTL_WRITE_MASK) : ctl_r;
    assign code_nxt     = wr_load ? wr_word : (tmr_hit ? tmr_word : code_r);
    assign high_lat_nxt = wr_load ? i_sfr.wdata : (tmr_hit ? high_r : high_lat_r);

    // Read mux; low returns written byte, high the latched byte
    assign rdata_nxt = !i_sfr.rd                           ? 8'h00 :
                       (i_sfr.addr == dou_pkg::ADDR_DATA_LOW)  ? low_r :
                       (i_sfr.addr == dou_pkg::ADDR_DATA_HIGH) ? high_lat_r :
                       (i_sfr.addr == dou_pkg::ADDR_CONTROL)   ? ctl_r : 8'h00;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Held bytes as written
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_r  <= dou_pkg::RST_DATA_LOW;
            high_r <= dou_pkg::RST_DATA_HIGH;
        end else begin
            low_r  <= low_nxt;
            high_r <= high_nxt;
        end
    end

    // Control byte
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_r <= dou_pkg::RST_CONTROL;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // Converter input latch and its high byte
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            high_lat_r <= dou_pkg::RST_DATA_HIGH;
            code_r     <= dou_pkg::RST_CODE;
        end else begin
            high_lat_r <= high_lat_nxt;
            code_r     <= code_nxt;
        end
    end

    // Read data, one cycle per strobe
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Pin enable and shutdown
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            enable_r   <= 1'b0;
            shutdown_r <= 1'b1;
        end else begin
            enable_r   <= en_nxt;
            shutdown_r <= !en_nxt;
        end
    end

    assign o_sfr_rdata     = rdata_r;
    assign o_conv_code     = code_r;
    assign o_conv_enable   = enable_r;
    assign o_conv_shutdown = shutdown_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_ctl_write(logic b);
        wr_ctl && (i_sfr.wdata[dou_pkg::CTL_ENABLE_BIT] == b);
    endsequence

    sequence s_quiet;
        !wr_ctl [*2];
    endsequence

    AST_DISABLE_SHUTS: assert property (s_ctl_write(1'b0) ##1 s_quiet |->
        !o_conv_enable && o_conv_shutdown)
        else $error("Disabled converter not shut down");

    AST_ENABLE_DRIVES: assert property (s_ctl_write(1'b1) |=>
        o_conv_enable && !o_conv_shutdown)
        else $error("Enabled converter not driving");

    AST_UNUSED_ZERO: assert property (i_sfr.rd && i_sfr.addr == dou_pkg::ADDR_CONTROL |=>
        o_sfr_rdata[6:5] == 2'b00)
        else $error("Unused control bits read nonzero");

    AST_WRITE_UPDATE: assert property (mode == dou_pkg::DOU_MODE_ON_WRITE && wr_high |=>
        o_conv_code == fmt_word($past(fmt), $past(i_sfr.wdata), $past(low_r)))
        else $error("High write did not load latch");

    property p_timer_load(logic pulse, dou_pkg::dou_mode_type m);
        mode == m && pulse |=> o_conv_code == fmt_word($past(fmt), $past(high_r), $past(low_r));
    endproperty

    AST_TMR3_LOAD: assert property (p_timer_load(i_ovf.tmr3, dou_pkg::DOU_MODE_TIMER3))
        else $error("Timer 3 overflow did not load latch");
    AST_TMR4_LOAD: assert property (p_timer_load(i_ovf.tmr4, dou_pkg::DOU_MODE_TIMER4))
        else $error("Timer 4 overflow did not load latch");
    AST_TMR2_LOAD: assert property (p_timer_load(i_ovf.tmr2, dou_pkg::DOU_MODE_TIMER2))
        else $error("Timer 2 overflow did not load latch");

    AST_LOW_HELD: assert property (!wr_load && !tmr_hit |=> $stable(o_conv_code))
        else $error("Latch changed without a load");

    AST_TIMER_HOLDS: assert property (mode != dou_pkg::DOU_MODE_ON_WRITE && !tmr_hit |=>
        $stable(o_conv_code) && $stable(high_lat_r))
        else $error("Timer mode latch changed without overflow");

    AST_LOW_READBACK: assert property (wr_low ##1 (i_sfr.rd && i_sfr.addr == dou_pkg::ADDR_DATA_LOW) |=>
        o_sfr_rdata == $past(i_sfr.wdata, 2))
        else $error("Low read not the written value");

    AST_HIGH_READBACK: assert property (i_sfr.rd && i_sfr.addr == dou_pkg::ADDR_DATA_HIGH |=>
        o_sfr_rdata == $past(high_lat_r))
        else $error("High read not the latched value");

    AST_FMT_WIDE: assert property (fmt[2] && wr_load |=>
        o_conv_code[3:0] == $past(low_r[7:4]))
        else $error("Wide format low nibble wrong");

    // ----------------------------------------------------------------
    // Field placement, alignment and holding
    // ----------------------------------------------------------------
    sequence s_ctl_read;
        i_sfr.rd && (i_sfr.addr == dou_pkg::ADDR_CONTROL);
    endsequence

    AST_SHUTDOWN_INVERSE: assert property (o_conv_shutdown == !o_conv_enable)
        else $error("Shutdown and enable disagree");

    AST_CTL_READBACK: assert property (wr_ctl ##1 s_ctl_read |=>
        o_sfr_rdata[6:5] == 2'b00 && o_sfr_rdata[4:0] == $past(i_sfr.wdata[4:0], 2) &&
        o_sfr_rdata[7] == $past(i_sfr.wdata[7], 2))
        else $error("Control readback not the masked write");

    AST_MODE_FIELD: assert property (wr_ctl |=>
        mode == $past(i_sfr.wdata[dou_pkg::CTL_MODE_HI:dou_pkg::CTL_MODE_LO]))
        else $error("Update mode field not from bits 4:3");

    AST_FMT_FIELD: assert property (wr_ctl |=>
        fmt == $past(i_sfr.wdata[dou_pkg::CTL_FMT_HI:dou_pkg::CTL_FMT_LO]))
        else $error("Data format field not from bits 2:0");

    AST_FMT_NIBBLE: assert property (fmt == dou_pkg::DOU_FMT_NIBBLE && wr_load |=>
        o_conv_code == {$past(i_sfr.wdata[3:0]), $past(low_r)})
        else $error("Format 000 alignment wrong");

    AST_FMT_FIVE: assert property (fmt == dou_pkg::DOU_FMT_FIVE && wr_load |=>
        o_conv_code == {$past(i_sfr.wdata[4:0]), $past(low_r[7:1])})
        else $error("Format 001 alignment wrong");

    AST_FMT_SIX: assert property (fmt == dou_pkg::DOU_FMT_SIX && wr_load |=>
        o_conv_code == {$past(i_sfr.wdata[5:0]), $past(low_r[7:2])})
        else $error("Format 010 alignment wrong");

    AST_FMT_SEVEN: assert property (fmt == dou_pkg::DOU_FMT_SEVEN && wr_load |=>
        o_conv_code == {$past(i_sfr.wdata[6:0]), $past(low_r[7:3])})
        else $error("Format 011 alignment wrong");

    AST_LOW_PRELATCH: assert property (mode == dou_pkg::DOU_MODE_ON_WRITE && wr_low |=>
        $stable(o_conv_code))
        else $error("Low write changed the latch");

    AST_TIMER_WRITE_HELD: assert property ((wr_low || wr_high) && !tmr_hit &&
        mode != dou_pkg::DOU_MODE_ON_WRITE |=> $stable(o_conv_code))
        else $error("Timer mode write reached the latch");

    AST_HIGH_LAT_WRITE: assert property (wr_load |=>
        high_lat_r == $past(i_sfr.wdata))
        else $error("High write not latched for readback");

    AST_TIMER_HIGH_COPY: assert property (tmr_hit |=>
        high_lat_r == $past(high_r))
        else $error("Overflow did not copy held high byte");

    AST_ONE_LOAD: assert property (tmr_hit ##1 (!tmr_hit && !wr_load) |=>
        $stable(o_conv_code))
        else $error("Overflow pulse loaded more than once");

    AST_MODE00_IGNORES: assert property (mode == dou_pkg::DOU_MODE_ON_WRITE && !wr_high |=>
        $stable(o_conv_code))
        else $error("Write mode latch changed without high write");

    AST_IDLE_RDATA: assert property (!i_sfr.rd |=>
        o_sfr_rdata == 8'h00)
        else $error("Read data not zero without a strobe");

endmodule

`default_nettype wire

// *** core/dou_pkg.sv ***
// Purpose: Shared constants and types for the converter-one update and format block
// Assumes: 8-bit special-function-register bus, one system clock
// Notes:   Offsets are byte addresses on the register bus
package dou_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA_LOW  = 8'hd5;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hd6;
    localparam logic [7:0] ADDR_CONTROL   = 8'hd7;

    localparam logic [7:0] RST_DATA_LOW   = 8'h00;
    localparam logic [7:0] RST_DATA_HIGH  = 8'h00;
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam logic [11:0] RST_CODE      = 12'h000;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_MODE_HI    = 4;
    localparam int CTL_MODE_LO    = 3;
    localparam int CTL_FMT_HI     = 2;
    localparam int CTL_FMT_LO     = 0;
    // Writable bits; bits 6 and 5 stay zero
    localparam logic [7:0] CTL_WRITE_MASK = 8'h9f;

    typedef enum logic [1:0] {
        DOU_MODE_ON_WRITE = 2'h0,
        DOU_MODE_TIMER3   = 2'h1,
        DOU_MODE_TIMER4   = 2'h2,
        DOU_MODE_TIMER2   = 2'h3
    } dou_mode_type;

    typedef enum logic [2:0] {
        DOU_FMT_NIBBLE = 3'h0,
        DOU_FMT_FIVE   = 3'h1,
        DOU_FMT_SIX    = 3'h2,
        DOU_FMT_SEVEN  = 3'h3
    } dou_fmt_type;

    // ----------------------------------------------------------------
    // Bus and event carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dou_sfr_req_type;

    typedef struct packed {
        logic tmr2;
        logic tmr3;
        logic tmr4;
    } dou_ovf_type;

endpackage

// *** test/dou_cpu_model.sv ***
// Purpose: Processor side model driving the register bus
// Assumes: One strobe per request, changed 1 ns after the rising edge
// Notes:   Released address and data show their inverse
`timescale 1ns/1ps
`default_nettype none
module dou_cpu_model (
    input  wire logic                     i_sys_clk,
    input  wire logic [7:0]               i_sfr_rdata,
    output var  dou_pkg::dou_sfr_req_type o_sfr
);
    initial o_sfr = '0;
    // Low byte always written before high byte by callers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    // Write, then read back at the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
        q = i_sfr_rdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge i_sys_clk);
        #1 o_sfr = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
        q = i_sfr_rdata;
    endtask
endmodule
`default_nettype wire

// *** test/tb_dac_one_update_and_format.sv ***
// Purpose: Self-checking bench for the converter-one control block
// Assumes: Register bus driven through the processor model
// Notes:   Expected codes built from the alignment table
`timescale 1ns/1ps
`default_nettype none
module tb_dac_one_update_and_format;
    logic                     i_sys_clk = 1'b0;
    logic                     i_reset_n = 1'b0;
    dou_pkg::dou_ovf_type     ovf       = '0;
    dou_pkg::dou_sfr_req_type sfr;
    logic [7:0]               rdata;
    logic [11:0]              code;
    logic                     en;
    logic                     sd;
    int                       mismatches = 0;
    int                       n_compared = 0;
    int                       cycles     = 0;

    dou_cpu_model cpu_i (.i_sys_clk(i_sys_clk), .i_sfr_rdata(rdata), .o_sfr(sfr));
    dou_conv1_ctrl dou_conv1_ctrl_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_sfr(sfr),
        .i_ovf(ovf), .o_sfr_rdata(rdata), .o_conv_code(code), .o_conv_enable(en),
        .o_conv_shutdown(sd));

    initial forever #2 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        cpu_i.rd(a, q);
        check(12'(q), 12'(exp));
    endtask
    task automatic pulse(input logic [2:0] b);
        @(posedge i_sys_clk);
        #1 ovf = dou_pkg::dou_ovf_type'(b);
        @(posedge i_sys_clk);
        #1 ovf = '0;
    endtask
    function automatic logic [11:0] fmt(input int f, input logic [7:0] h, input logic [7:0] l);
        if (f >= 4) return {h, l[7:4]};
        if (f == 3) return {h[6:0], l[7:3]};
        if (f == 2) return {h[5:0], l[7:2]};
        if (f == 1) return {h[4:0], l[7:1]};
        return {h[3:0], l};
    endfunction
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        logic [7:0]  h;
        logic [7:0]  l;
        logic [7:0]  c;
        logic [2:0]  sel;
        logic [11:0] exp;
        logic [7:0]  q;
        exp = 12'h000;
        repeat (3) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b1;
        check(code, 12'h000);
        check(12'(en), 12'h000);
        check(12'(sd), 12'h001);
        rdchk(dou_pkg::ADDR_DATA_LOW, 8'h00);
        rdchk(dou_pkg::ADDR_DATA_HIGH, 8'h00);
        rdchk(dou_pkg::ADDR_CONTROL, 8'h00);
        rdchk(8'h00, 8'h00);
        cpu_i.wr_rd(dou_pkg::ADDR_CONTROL, 8'hff, q);
        check(12'(q), 12'h09f);
        check(12'(en), 12'h001);
        check(12'(sd), 12'h000);
        rdchk(dou_pkg::ADDR_CONTROL, 8'h9f);
        for (int f = 0; f < 8; f++) begin
            h = 8'hc3 ^ 8'(f * 8'h35);
            l = 8'h9e ^ 8'(f * 8'h47);
            cpu_i.wr(dou_pkg::ADDR_CONTROL, 8'h80 | 8'(f));
            cpu_i.wr(dou_pkg::ADDR_DATA_LOW, l);
            check(code, exp);
            cpu_i.wr(dou_pkg::ADDR_DATA_HIGH, h);
            exp = fmt(f, h, l);
            check(code, exp);
        end
        rdchk(dou_pkg::ADDR_DATA_LOW, l);
        pulse(3'h7);
        check(code, exp);
        for (int m = 1; m < 4; m++) begin
            sel = (m == 1) ? 3'h2 : (m == 2) ? 3'h1 : 3'h4;
            c = 8'h80 | 8'(m << 3) | 8'(m);
            cpu_i.wr_rd(dou_pkg::ADDR_CONTROL, c, q);
            check(12'(q), 12'(c));
            rdchk(dou_pkg::ADDR_CONTROL, c);
            cpu_i.wr_rd(dou_pkg::ADDR_DATA_LOW, 8'h11 * 8'(m), q);
            check(12'(q), 12'(8'h11 * 8'(m)));
            cpu_i.wr(dou_pkg::ADDR_DATA_HIGH, 8'hf0 - 8'h13 * 8'(m));
            check(code, exp);
            rdchk(dou_pkg::ADDR_DATA_HIGH, h);
            pulse(~sel);
            check(code, exp);
            pulse(sel);
            h = 8'hf0 - 8'h13 * 8'(m);
            exp = fmt(m, h, 8'h11 * 8'(m));
            check(code, exp);
            rdchk(dou_pkg::ADDR_DATA_HIGH, h);
        end
        cpu_i.wr(dou_pkg::ADDR_CONTROL, 8'h00);
        check(12'(en), 12'h000);
        check(12'(sd), 12'h001);
        repeat (2) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b1;
        check(code, 12'h000);
        check(12'(en), 12'h000);
        check(12'(sd), 12'h001);
        rdchk(dou_pkg::ADDR_DATA_LOW, 8'h00);
        rdchk(dou_pkg::ADDR_DATA_HIGH, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
